/* rtl/occh_pkg.sv */
// Constants, types and reset values for the output compare channel.
// Assumes an APB master with 32-bit data and two external 16-bit timers.
package occh_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_MAIN = 8'h04;
    localparam logic [7:0] OFS_SEC  = 8'h08;
    localparam logic [7:0] OFS_FLAG = 8'h0c;
    localparam logic [7:0] OFS_IEN  = 8'h10;

    // Control field positions
    localparam int CTL_MODE_LSB = 0;
    localparam int CTL_TSEL_BIT = 3;
    localparam int CTL_FLT_BIT  = 4;
    localparam int CTL_SIDL_BIT = 13;

    // Flag and enable bit positions
    localparam int FLG_CMP = 0;
    localparam int FLG_T1  = 1;
    localparam int FLG_T2  = 2;

    // Oscillator periods per timer increment
    localparam int TOSC_PER_TCY = 4;

    typedef enum logic [2:0] {
        MODE_OFF    = 3'h0,
        MODE_CLR    = 3'h1,
        MODE_SET    = 3'h2,
        MODE_TGL    = 3'h3,
        MODE_SPULSE = 3'h4,
        MODE_CPULSE = 3'h5,
        MODE_PWM    = 3'h6,
        MODE_PWMF   = 3'h7
    } occh_mode_e;

    typedef enum logic [3:0] {
        ST_OFF   = 4'h1,
        ST_RUN   = 4'h2,
        ST_DONE  = 4'h4,
        ST_FAULT = 4'h8
    } occh_state_e;

    // One timer as seen by the channel
    typedef struct packed {
        logic [15:0] count;
        logic [15:0] period;
        logic        tick;
        logic        run;
        logic        idle_stop;
    } occh_tmr_s;

    // Whole state of the channel
    typedef struct packed {
        occh_state_e state;
        occh_mode_e  mode;
        logic        tsel;
        logic        sidl;
        logic        fault;
        logic [15:0] main;
        logic [15:0] sec;
        logic [2:0]  flags;
        logic [2:0]  ien;
        logic [2:0]  irq;
        logic        pin;
        logic        oe_n;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } occh_state_s;

    localparam occh_state_s OCCH_STATE_RST = '{state: ST_OFF, mode: MODE_OFF, default: '0};

endpackage

/* rtl/occh_tmr_sel.sv */
// Timer source selection and run qualification for one channel.
// Assumes timer inputs are synchronous to pclk; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module occh_tmr_sel
    import occh_pkg::*;
(
    input  wire occh_tmr_s [1:0] timers,
    input  wire logic            tsel,
    input  wire logic            chan_idle_stop,
    input  wire logic            idle_mode,
    input  wire logic            sleep_mode,
    output occh_tmr_s            sel,
    output logic                 active
);

    assign sel = timers[tsel];

    assign active = !sleep_mode
                  && (!idle_mode || (!chan_idle_stop && sel.run && !sel.idle_stop));

endmodule
`default_nettype wire

/* rtl/occh_top.sv */
// Output compare channel: single-edge, pulse and PWM modes with APB registers.
// Assumes two external timers that strobe tick with each new count value.
//
// Functional notes
// - Compare against one of two timers
// - Modes 001/010/011 clear, set, toggle pin
// - Single-edge acts when count equals main
// - Wrap before match leaves pin alone
// - Mode 100 single pulse, 101 continuous
// - Single pulse rearmed by rewriting 100
// - PWM main is read-only, loaded from secondary
// - Mode 111 fault low releases pin
// - Fault status flag reports fault
// - Fault holds until removed and rewritten
// - PWM period follows timer period plus one
// - Period end: set pin, load duty, flag
// - Zero duty keeps pin low
// - Duty above period keeps pin high
// - Sleep holds pin level
// - Idle run needs both stop bits clear
// - Single-edge and secondary matches set compare flag
// - PWM sets timer flag, never compare
// - Dual modes: main first, secondary second
`timescale 1ns/1ps
`default_nettype none
module occh_top
    import occh_pkg::*;
(
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [7:0]      paddr,
    input  wire logic [31:0]     pwdata,
    output logic [31:0]          prdata,
    output logic                 pready,
    output logic                 pslverr,
    input  wire occh_tmr_s [1:0] timers,
    input  wire logic            fault_input_pin,
    input  wire logic            idle_mode,
    input  wire logic            sleep_mode,
    output logic                 compare_output_pin,
    output logic                 compare_output_oe_n,
    output logic [2:0]           irq
);

    occh_state_s st;
    occh_state_s next_st;
    occh_tmr_s   sel;
    logic        active;
    logic        tick;
    logic        main_hit;
    logic        sec_hit;
    logic        prd_start;
    logic        access;
    logic        wr;
    logic        ctl_wr;
    logic        is_pwm;
    logic [2:0]  flag_set;
    logic [2:0]  flag_clr;
    occh_mode_e  wr_mode;

    occh_tmr_sel u_sel (
        .timers         (timers),
        .tsel           (st.tsel),
        .chan_idle_stop (st.sidl),
        .idle_mode      (idle_mode),
        .sleep_mode     (sleep_mode),
        .sel            (sel),
        .active         (active)
    );

    // Compare events, only on a fresh count while running
    assign tick      = active && sel.tick;
    assign main_hit  = tick && (sel.count == st.main);
    assign sec_hit   = tick && (sel.count == st.sec);
    assign prd_start = tick && (sel.count == 16'h0000);
    assign is_pwm    = (st.mode == MODE_PWM) || (st.mode == MODE_PWMF);

    // Bus strobes; a write lands on the edge where pready is seen high
    assign access  = psel && penable && !st.pready;
    assign wr      = psel && penable && pwrite && st.pready;
    assign ctl_wr  = wr && (paddr == OFS_CTRL);
    assign wr_mode = occh_mode_e'(pwdata[CTL_MODE_LSB +: 3]);

    // Next-state logic
    always_comb begin
        next_st  = st;
        flag_set = 3'h0;
        flag_clr = 3'h0;

        // Channel behaviour per state and mode
        case (st.state)
            ST_RUN: begin
                case (st.mode)
                    MODE_CLR, MODE_SET, MODE_TGL: begin
                        if (main_hit) begin
                            if (st.mode == MODE_CLR) begin
                                next_st.pin = 1'b0;
                            end else if (st.mode == MODE_SET) begin
                                next_st.pin = 1'b1;
                            end else begin
                                next_st.pin = !st.pin;
                            end
                            flag_set[FLG_CMP] = 1'b1;
                        end
                    end
                    MODE_SPULSE, MODE_CPULSE: begin
                        if (main_hit) begin
                            next_st.pin = 1'b1;
                        end
                        if (sec_hit) begin
                            next_st.pin = 1'b0;
                            flag_set[FLG_CMP] = 1'b1;
                            if (st.mode == MODE_SPULSE) begin
                                next_st.state = ST_DONE;
                            end
                        end
                    end
                    MODE_PWM, MODE_PWMF: begin
                        if (st.mode == MODE_PWMF && !fault_input_pin) begin
                            next_st.state = ST_FAULT;
                            next_st.oe_n  = 1'b1;
                            next_st.fault = 1'b1;
                        end else if (prd_start) begin
                            next_st.main = st.sec;
                            next_st.pin  = (st.sec != 16'h0000);
                            flag_set[st.tsel ? FLG_T2 : FLG_T1] = 1'b1;
                        end else if (main_hit) begin
                            next_st.pin = 1'b0;
                        end
                    end
                    default: begin
                        next_st.state = ST_OFF;
                    end
                endcase
            end
            // Waiting for software; nothing compares here
            ST_OFF, ST_DONE, ST_FAULT: begin
                next_st.state = st.state;
            end
            default: begin
                next_st.state = ST_OFF;
            end
        endcase

        // Register writes, taken on the completing edge
        if (ctl_wr) begin
            next_st.mode = wr_mode;
            next_st.tsel = pwdata[CTL_TSEL_BIT];
            next_st.sidl = pwdata[CTL_SIDL_BIT];
            if (wr_mode == MODE_OFF) begin
                next_st.state = ST_OFF;
            end else if (st.state == ST_FAULT && !fault_input_pin) begin
                next_st.state = ST_FAULT;
            end else begin
                next_st.state = ST_RUN;
                next_st.oe_n  = 1'b0;
                next_st.fault = 1'b0;
            end
        end
        if (wr && paddr == OFS_MAIN && !is_pwm) begin
            next_st.main = pwdata[15:0];
        end
        if (wr && paddr == OFS_SEC) begin
            next_st.sec = pwdata[15:0];
        end
        if (wr && paddr == OFS_IEN) begin
            next_st.ien = pwdata[2:0];
        end
        if (wr && paddr == OFS_FLAG) begin
            flag_clr = pwdata[2:0];
        end

        // Write-one-to-clear; a new event beats the clear
        next_st.flags = (st.flags & ~flag_clr) | flag_set;
        next_st.irq   = next_st.flags & next_st.ien;

        // APB answer: one wait state, data and error ready with pready
        next_st.pready  = access;
        next_st.pslverr = 1'b0;
        if (access) begin
            next_st.prdata = 32'h0000_0000;
            case (paddr)
                OFS_CTRL: begin
                    next_st.prdata[CTL_MODE_LSB +: 3] = st.mode;
                    next_st.prdata[CTL_TSEL_BIT]      = st.tsel;
                    next_st.prdata[CTL_FLT_BIT]       = st.fault;
                    next_st.prdata[CTL_SIDL_BIT]      = st.sidl;
                end
                OFS_MAIN: begin
                    next_st.prdata[15:0] = st.main;
                end
                OFS_SEC: begin
                    next_st.prdata[15:0] = st.sec;
                end
                OFS_FLAG: begin
                    next_st.prdata[2:0] = st.flags;
                end
                OFS_IEN: begin
                    next_st.prdata[2:0] = st.ien;
                end
                default: begin
                    // Unmapped: error, reads zero, writes dropped by decode
                    next_st.pslverr = 1'b1;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= OCCH_STATE_RST;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state flops
    assign prdata              = st.prdata;
    assign pready              = st.pready;
    assign pslverr             = st.pslverr;
    assign compare_output_pin  = st.pin;
    assign compare_output_oe_n = st.oe_n;
    assign irq                 = st.irq;

    // Checks on the channel behaviour
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_run_mode(occh_mode_e m);
        st.state == ST_RUN && st.mode == m && !ctl_wr;
    endsequence

    sequence s_pwm_start;
        st.state == ST_RUN && is_pwm && !ctl_wr && prd_start
            && !(st.mode == MODE_PWMF && !fault_input_pin);
    endsequence

    property p_clr_match;
        s_run_mode(MODE_CLR) ##0 main_hit |=> !compare_output_pin && st.flags[FLG_CMP];
    endproperty
    a_clr_match: assert property (p_clr_match) else $error("clear mode pin not low");

    property p_tgl_match;
        s_run_mode(MODE_TGL) ##0 main_hit |=> compare_output_pin != $past(compare_output_pin);
    endproperty
    a_tgl_match: assert property (p_tgl_match) else $error("toggle mode pin unchanged");

    property p_no_hit_hold;
        s_run_mode(MODE_SET) ##0 !main_hit |=> compare_output_pin == $past(compare_output_pin);
    endproperty
    a_no_hit_hold: assert property (p_no_hit_hold) else $error("pin moved without match");

    property p_single_done;
        s_run_mode(MODE_SPULSE) ##0 sec_hit |=> st.state == ST_DONE && !compare_output_pin
            ##1 (st.state == ST_DONE || $past(ctl_wr));
    endproperty
    a_single_done: assert property (p_single_done) else $error("single pulse not finished");

    property p_pwm_load;
        s_pwm_start |=> st.main == $past(st.sec)
            && compare_output_pin == ($past(st.sec) != 16'h0000);
    endproperty
    a_pwm_load: assert property (p_pwm_load) else $error("period start load wrong");

    property p_pwm_no_cmp;
        is_pwm && !st.flags[FLG_CMP] |=> !st.flags[FLG_CMP];
    endproperty
    a_pwm_no_cmp: assert property (p_pwm_no_cmp) else $error("compare flag set in PWM");

    property p_fault_release;
        s_run_mode(MODE_PWMF) ##0 !fault_input_pin |=> compare_output_oe_n && st.fault
            ##1 (compare_output_oe_n || $past(ctl_wr));
    endproperty
    a_fault_release: assert property (p_fault_release) else $error("fault did not release");

    property p_fault_hold;
        st.state == ST_FAULT && !fault_input_pin |=> st.state == ST_FAULT && compare_output_oe_n;
    endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("fault left too early");

    property p_sleep_hold;
        sleep_mode && !ctl_wr |=> $stable(compare_output_pin) && $stable(st.flags[FLG_CMP]);
    endproperty
    a_sleep_hold: assert property (p_sleep_hold) else $error("pin moved in sleep");

    property p_off_quiet;
        st.state == ST_OFF && !st.flags[FLG_CMP] |=> !st.flags[FLG_CMP];
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("flag set while disabled");

    property p_set_match;
        s_run_mode(MODE_SET) ##0 main_hit |=> compare_output_pin && st.flags[FLG_CMP];
    endproperty
    a_set_match: assert property (p_set_match) else $error("set mode pin not high");

    property p_pulse_start;
        s_run_mode(MODE_CPULSE) ##0 main_hit && !sec_hit
            |=> compare_output_pin && st.state == ST_RUN;
    endproperty
    a_pulse_start: assert property (p_pulse_start) else $error("pulse did not start");

    property p_pwm_no_event_hold;
        s_run_mode(MODE_PWM) ##0 !prd_start && !main_hit |=> $stable(compare_output_pin);
    endproperty
    a_pwm_no_event_hold: assert property (p_pwm_no_event_hold) else $error("PWM pin moved");

    property p_main_locked;
        is_pwm && !prd_start |=> $stable(st.main);
    endproperty
    a_main_locked: assert property (p_main_locked) else $error("main changed in PWM");

    property p_idle_stop;
        idle_mode && st.sidl && !ctl_wr |=> $stable(compare_output_pin);
    endproperty
    a_idle_stop: assert property (p_idle_stop) else $error("pin moved in stopped idle");

endmodule
`default_nettype wire

/* testbench/occh_load.sv */
// Load on the compare pin: a weak pull-down and a rising-edge counter.
// Assumes pin and enable come straight from the channel, same clock.
`timescale 1ns/1ps
`default_nettype none
module occh_load (
    input  wire logic  pclk,
    input  wire logic  pin,
    input  wire logic  oe_n,
    output logic       level,
    output logic [7:0] rises
);
    logic prev;
    assign level = oe_n ? 1'b0 : pin;
    // Edge count shows pulses the bench cannot watch cycle by cycle
    initial rises = 8'h00;
    initial prev = 1'b0;
    always @(posedge pclk) begin
        prev <= level;
        if (level && !prev) rises <= rises + 8'h01;
    end
endmodule
`default_nettype wire

/* testbench/output_compare_channel_test.sv */
// Self-checking bench for the output compare channel.
// Assumes the bench models both timers and drives APB at rising edges.
`timescale 1ns/1ps
`default_nettype none
module output_compare_channel_test;
    import occh_pkg::*;
    typedef struct packed {
        occh_mode_e  mode;
        logic        tsel;
        logic        trn;
        logic [15:0] main;
        logic [7:0]  n;
        logic        pin;
        logic        flag;
    } occh_row_s;
    logic            pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic            flt, idle, sleep, pin, oe_n, level, tclr, err, tidl;
    logic [7:0]      paddr, rises, r0;
    logic [31:0]     pwdata, prdata, rd;
    logic [2:0]      irq;
    logic [1:0]      trun;
    logic [15:0]     tper [2];
    occh_tmr_s [1:0] timers;
    int              errors = 0;
    int              tests_run = 0;
    int              cyc = 0;
    occh_row_s       rows [7] = '{
        '{MODE_SET, 1'b0, 1'b0, 16'h0005, 8'h08, 1'b1, 1'b1},
        '{MODE_CLR, 1'b1, 1'b1, 16'h0005, 8'h08, 1'b0, 1'b1},
        '{MODE_TGL, 1'b0, 1'b0, 16'h0005, 8'h08, 1'b1, 1'b1},
        '{MODE_TGL, 1'b0, 1'b0, 16'h001e, 8'h19, 1'b1, 1'b0},
        '{MODE_CLR, 1'b1, 1'b0, 16'h0005, 8'h08, 1'b1, 1'b0},
        '{MODE_OFF, 1'b0, 1'b0, 16'h0003, 8'h08, 1'b1, 1'b0},
        '{MODE_CLR, 1'b0, 1'b0, 16'h0005, 8'h08, 1'b0, 1'b1}};

    occh_top i_occh_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timers(timers), .fault_input_pin(flt), .idle_mode(idle),
        .sleep_mode(sleep), .compare_output_pin(pin), .compare_output_oe_n(oe_n), .irq(irq));
    occh_load i_occh_load (.pclk(pclk), .pin(pin), .oe_n(oe_n), .level(level), .rises(rises));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // Timers: one tick per new count, wrap after the period value
    initial timers = '0;
    always @(posedge pclk) begin
        for (int i = 0; i < 2; i++) begin
            timers[i].tick <= trun[i];
            timers[i].run <= trun[i];
            timers[i].period <= tper[i];
            timers[i].idle_stop <= tidl;
            if (tclr) timers[i].count <= 16'h0000;
            else if (trun[i])
                timers[i].count <= (timers[i].count == tper[i]) ? 16'h0000
                                   : timers[i].count + 16'h0001;
        end
    end
    // Hang guard, far above the expected run length
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    // One APB transfer; ends on the rising edge that samples pready high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string msg);
        apb(1'b0, a, 32'h0);
        chk(rd, exp, msg);
    endtask
    // Run one timer for exactly n ticks, then let the pin settle
    task automatic run(input int t, input int n);
        @(posedge pclk);
        trun[t] <= 1'b1;
        repeat (n) @(posedge pclk);
        trun[t] <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask
    task automatic clr();
        @(posedge pclk);
        tclr <= 1'b1;
        @(posedge pclk);
        tclr <= 1'b0;
    endtask
    task report_and_stop();
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
        {flt, idle, sleep, trun, tclr, tidl} = 7'h40;
        tper[0] = 16'h0014;
        tper[1] = 16'h0014;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        wr(OFS_IEN, 32'h1);
        // Single-edge cases: compare value before mode, then run
        foreach (rows[i]) begin
            clr();
            wr(OFS_MAIN, {16'h0, rows[i].main});
            wr(OFS_CTRL, {28'h0, rows[i].tsel, rows[i].mode});
            run(rows[i].trn, rows[i].n);
            chk(pin, rows[i].pin, "edge pin");
            rdc(OFS_FLAG, rows[i].flag, "edge flag");
            chk(irq[0], rows[i].flag, "cmp irq");
            wr(OFS_FLAG, 32'h7);
        end
        // Single pulse, then rearm
        // Start and stop first
        wr(OFS_MAIN, 32'h3);
        wr(OFS_SEC, 32'h6);
        clr();
        wr(OFS_CTRL, MODE_SPULSE);
        r0 = rises;
        run(0, 8);
        chk(rises - r0, 1, "pulse");
        chk(pin, 0, "pulse end");
        rdc(OFS_FLAG, 32'h1, "pulse flag");
        run(0, 30);
        chk(rises - r0, 1, "no repeat");
        wr(OFS_CTRL, MODE_SPULSE);
        run(0, 10);
        chk(rises - r0, 2, "rearm");
        // Continuous pulses
        clr();
        wr(OFS_CTRL, MODE_CPULSE);
        r0 = rises;
        run(0, 44);
        chk(rises - r0, 2, "cont");
        // PWM: period 9 gives one pulse per 10 ticks
        // Period, duty, mode, timer
        tper[0] <= 16'h0009;
        clr();
        wr(OFS_SEC, 32'h4);
        wr(OFS_CTRL, MODE_PWM);
        wr(OFS_FLAG, 32'h7);
        wr(OFS_IEN, 32'h7);
        r0 = rises;
        run(0, 40);
        chk(rises - r0, 4, "pwm rate");
        chk(pin, 1, "pwm start");
        rdc(OFS_FLAG, 32'h2, "pwm flag");
        chk(irq, 3'h2, "timer irq");
        rdc(OFS_MAIN, 32'h4, "duty load");
        wr(OFS_MAIN, 32'h7);
        rdc(OFS_MAIN, 32'h4, "main ro");
        wr(OFS_SEC, 32'h0);
        r0 = rises;
        run(0, 20);
        chk({rises - r0, 7'h0, pin}, 0, "duty zero");
        wr(OFS_SEC, 32'hf);
        r0 = rises;
        run(0, 20);
        chk({rises - r0, 7'h0, pin}, 16'h0101, "duty big");
        // Sleep holds the pin, wake resumes
        sleep <= 1'b1;
        wr(OFS_SEC, 32'h0);
        run(0, 20);
        chk(pin, 1, "sleep");
        sleep <= 1'b0;
        run(0, 10);
        chk(pin, 0, "wake");
        // Idle with and without the channel stop bit
        idle <= 1'b1;
        wr(OFS_CTRL, 32'h2006);
        wr(OFS_SEC, 32'hf);
        run(0, 10);
        chk(pin, 0, "idle stop");
        tidl <= 1'b1;
        wr(OFS_CTRL, MODE_PWM);
        run(0, 10);
        chk(pin, 0, "timer idle stop");
        tidl <= 1'b0;
        wr(OFS_CTRL, MODE_PWM);
        run(0, 10);
        chk(pin, 1, "idle run");
        idle <= 1'b0;
        // Fault: release, report, hold until removed and rewritten
        wr(OFS_CTRL, MODE_PWMF);
        flt <= 1'b0;
        repeat (3) @(posedge pclk);
        chk({oe_n, level}, 2'b10, "fault");
        rdc(OFS_CTRL, 32'h17, "fault flag");
        wr(OFS_CTRL, MODE_PWMF);
        flt <= 1'b1;
        repeat (3) @(posedge pclk);
        chk(oe_n, 1, "fault held");
        wr(OFS_CTRL, MODE_PWMF);
        @(posedge pclk);
        chk(oe_n, 0, "fault left");
        rdc(OFS_CTRL, 32'h7, "flag cleared");
        // Unmapped address, then a reset in mid-run
        apb(1'b0, 8'h14, 32'h0);
        chk(err, 1, "unmapped error");
        chk(rd, 0, "unmapped data");
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({pin, oe_n}, 0, "reset pin");
        presetn <= 1'b1;
        rdc(OFS_CTRL, 32'h0, "reset ctrl");
        rdc(OFS_MAIN, 32'h0, "reset main");
        report_and_stop();
    end
endmodule
`default_nettype wire
